// >>> core/clock_sync_cfg.svh
`ifndef CLOCK_SYNC_CFG_SVH
`define CLOCK_SYNC_CFG_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define CS_ADDR_W            8
`define CS_OFS_CTRL          8'h00
`define CS_OFS_G4_DELAY      8'h04
`define CS_OFS_DIVIDE        8'h08
`define CS_OFS_BANK_B_WORD   8'h0C
`define CS_OFS_BANK_AB_WORD  8'h10
`define CS_OFS_STATUS        8'h14

// ****************************************************************
// field positions
// ****************************************************************
`define CS_CTRL_W            12
`define CS_DIV_G4_LSB        0
`define CS_DIV_G1_LSB        12
`define CS_DIV_G2_LSB        16
`define CS_DIV_G3_LSB        20
`define CS_ST_PIN_BIT        0
`define CS_ST_HOLD_LSB       1
`define CS_ST_HELD_LSB       3
`define CS_ST_DELAY_LSB      7

// ****************************************************************
// reset values
// ****************************************************************
`define CS_CTRL_RST          12'h0C0
`define CS_G4_DELAY_RST      10'h005
`define CS_G4_DIV_RST        11'h001
`define CS_GRP_DIV_RST       4'h1

// ****************************************************************
// delay range and timing
// ****************************************************************
`define CS_G4_DELAY_MIN      10'h005
`define CS_G4_DELAY_MAX      10'h20A
`define CS_CLOCK_PERIOD_NS   100
`define CS_AUTO_DELAY_NS     170
`define CS_LOW_G13_HALF      9
`define CS_LOW_G4_D1_HALF    11
`define CS_LOW_G4_DN_HALF    13
`define CS_RELEASE_CYCLES    5
`define CS_OFFSET_CYCLES     5
`define CS_ONESHOT_CYCLES    3

`endif

// >>> core/clock_sync_pkg.sv
package clock_sync_pkg;

  // control register layout, bit 0 at the bottom
  typedef struct packed {
    logic [1:0] sync_qualify_select;
    logic       group4_half_step;
    logic [2:0] fixed_offset_power_down;
    logic [3:0] group_sync_exclude;
    logic       auto_sync_enable;
    logic       sync_polarity_invert;
  } ctrl_t;

  // avalon slave request bundle
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avl_req_t;

  // per group divider state
  typedef struct packed {
    logic        held;
    logic [10:0] wait_cnt;
    logic [10:0] cnt;
    logic        out;
  } div_state_t;

endpackage

// >>> core/sync_pin_synchronizer.sv
`timescale 1ns/100ps
`default_nettype none

module sync_pin_synchronizer
  import clock_sync_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      pin_sync_o
);

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_t;

  sync_state_t state_r;
  sync_state_t state_nxt;

  // two stage chain, first stage read only by the second
  always_comb begin
    state_nxt.meta   = pin_i;
    state_nxt.stable = state_r.meta;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pin_sync_o = state_r.stable;

endmodule

`default_nettype wire

// >>> core/group_divider.sv
`timescale 1ns/100ps
`default_nettype none

module group_divider
  import clock_sync_pkg::*;
#(
  parameter int DIV_W = 11
)
(
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             enable_i,
  input  wire logic             assert_i,
  input  wire logic             bank_hold_i,
  input  wire logic [10:0]      wait_i,
  input  wire logic [DIV_W-1:0] divide_i,
  output logic                  clk_o,
  output logic                  held_o
);

  div_state_t state_r;
  div_state_t state_nxt;
  logic [DIV_W-1:0] high_len;

  // first cycles of each period are high, ceil(divide/2)
  assign high_len = DIV_W'((divide_i + DIV_W'(1)) >> 1);

  // hold low, count release wait, then divide
  always_comb begin
    state_nxt = state_r;
    if (enable_i && assert_i) begin
      state_nxt.held     = 1'b1;
      state_nxt.wait_cnt = wait_i;
      state_nxt.out      = 1'b0;
      state_nxt.cnt      = '0;
    end else if (state_r.held) begin
      state_nxt.out = 1'b0;
      if (!bank_hold_i) begin
        if (state_r.wait_cnt <= 11'h001) begin
          // restart on a rising edge, at the top of the high phase
          state_nxt.held = 1'b0;
          state_nxt.out  = 1'b1;
          state_nxt.cnt  = '0;
        end else begin
          state_nxt.wait_cnt = state_r.wait_cnt - 11'h001;
        end
      end
    end else if (divide_i <= DIV_W'(1)) begin
      state_nxt.out = ~state_r.out;
      state_nxt.cnt = '0;
    end else begin
      state_nxt.cnt = (11'(state_r.cnt) + 11'h001 >= 11'(divide_i)) ? 11'h000
                      : state_r.cnt + 11'h001;
      state_nxt.out = (state_nxt.cnt < 11'(high_len));
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign clk_o  = state_r.out;
  assign held_o = state_r.held;

endmodule

`default_nettype wire

// >>> core/clock_output_sync_delay.sv
// Summary of operation
// - new group 4 coarse count is applied only at a sync event
// - group 4 half-step change reaches the output at once
// - count 5 with half-step clear gives zero offset to group 3
// - groups with sync exclude clear are synchronized together
// - synchronized outputs are held low while sync is asserted
// - on release synchronized outputs rise together apart from delays
// - pin polarity follows the invert bit, high is active when clear
// - a write toggling the invert bit raises a sync event
// - auto sync on bank B word write syncs bank B only
// - auto sync on bank A/B word write syncs both banks
// - auto sync event is registered 2 cycles (200 ns, 170 ns rounded up) after the write
// - excluded groups keep running through any sync event
// - later events resync included groups with current delays
// - all sync counts are in distribution clock cycles
// - groups 1-3 drop after 5 cycles, group 4 after 6 or 7 (half counts rounded up)
// - coarse count is limited to its legal range
// - offset bit clear adds 5 cycles before the rising edge
`include "clock_sync_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module clock_output_sync_delay
  import clock_sync_pkg::*;
#(
  parameter int DIV_W   = 11,
  parameter int DELAY_W = 10
)
(
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  input  wire logic [`CS_ADDR_W-1:0] address_i,
  input  wire logic                  read_i,
  input  wire logic                  write_i,
  input  wire logic [31:0]           writedata_i,
  input  wire logic [3:0]            byteenable_i,
  output logic [31:0]                readdata_o,
  output logic                       waitrequest_o,
  input  wire logic                  sync_pin_i,
  output logic [3:0]                 group_clk_o,
  output logic                       group4_half_step_o
);

  // ****************************************************************
  // timing counts derived from the distribution clock
  // ****************************************************************
  // counts in clock cycles
  localparam int AUTO_CYC_I = (`CS_AUTO_DELAY_NS + `CS_CLOCK_PERIOD_NS - 1)
                              / `CS_CLOCK_PERIOD_NS;
  localparam logic [1:0] AUTO_CYC   = 2'(AUTO_CYC_I < 1 ? 1 : AUTO_CYC_I);
  localparam int         LOW_G13    = (`CS_LOW_G13_HALF + 1) / 2;
  localparam int         LOW_G4_D1  = (`CS_LOW_G4_D1_HALF + 1) / 2;
  localparam int         LOW_G4_DN  = (`CS_LOW_G4_DN_HALF + 1) / 2;
  localparam logic [1:0] ONESHOT    = 2'(`CS_ONESHOT_CYCLES);
  localparam logic [10:0] RELEASE   = 11'(`CS_RELEASE_CYCLES);
  localparam logic [10:0] OFFSET    = 11'(`CS_OFFSET_CYCLES);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic               ack;
    logic [31:0]        rdata;
    ctrl_t              ctrl;
    logic [DELAY_W-1:0] delay_count;
    logic [DELAY_W-1:0] applied_delay;
    logic [DIV_W-1:0]   g4_divide;
    logic [2:0][3:0]    grp_divide;
    logic [31:0]        word_b;
    logic [31:0]        word_ab;
    logic [1:0]         manual_cnt;
    logic [1:0]         auto_wait;
    logic               auto_both;
    logic [1:0]         auto_cnt_a;
    logic [1:0]         auto_cnt_b;
    logic               hold_a;
    logic               hold_b;
    logic [7:0]         pipe_a;
    logic [7:0]         pipe_b;
    logic               half_step_out;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  avl_req_t          req;
  logic              pin_sync;
  logic              pin_active;
  logic              commit_wr;
  logic              req_a;
  logic              req_b;
  logic [31:0]       merged;
  logic [3:0]        grp_held;
  logic [3:0]        grp_assert;
  logic [3:0]        grp_hold;
  logic [3:0][10:0]  grp_wait;
  logic [3:0][DIV_W-1:0] grp_div;
  ctrl_t             ctrl_wr;
  logic [DELAY_W-1:0] delay_wr;

  assign req.address    = address_i;
  assign req.read       = read_i;
  assign req.write      = write_i;
  assign req.writedata  = writedata_i;
  assign req.byteenable = byteenable_i;

  // merge write data into an old word by byte lanes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // sync pin input
  // ****************************************************************
  // pin synchronizer
  sync_pin_synchronizer u_pin_sync (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .pin_i      (sync_pin_i),
    .pin_sync_o (pin_sync)
  );

  assign pin_active = pin_sync ^ state_r.ctrl.sync_polarity_invert;

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // one wait state on every access
  assign waitrequest_o = (req.read | req.write) & ~state_r.ack;
  assign commit_wr     = req.write & state_r.ack;
  assign readdata_o    = state_r.rdata;

  // write values seen by the register decode
  always_comb begin
    merged   = '0;
    ctrl_wr  = state_r.ctrl;
    delay_wr = state_r.delay_count;
    unique case (req.address)
      `CS_OFS_CTRL: begin
        merged  = lane_merge(32'(state_r.ctrl), req.writedata, req.byteenable);
        ctrl_wr = ctrl_t'(merged[`CS_CTRL_W-1:0]);
      end
      `CS_OFS_G4_DELAY: begin
        merged = lane_merge(32'(state_r.delay_count), req.writedata,
                            req.byteenable);
        if (merged < 32'(`CS_G4_DELAY_MIN)) begin
          delay_wr = `CS_G4_DELAY_MIN;
        end else if (merged > 32'(`CS_G4_DELAY_MAX)) begin
          delay_wr = `CS_G4_DELAY_MAX;
        end else begin
          delay_wr = merged[DELAY_W-1:0];
        end
      end
      `CS_OFS_DIVIDE: begin
        merged = lane_merge({8'h00, state_r.grp_divide, 1'b0, state_r.g4_divide},
                            req.writedata, req.byteenable);
      end
      `CS_OFS_BANK_B_WORD: begin
        merged = lane_merge(state_r.word_b, req.writedata, req.byteenable);
      end
      `CS_OFS_BANK_AB_WORD: begin
        merged = lane_merge(state_r.word_ab, req.writedata, req.byteenable);
      end
      default: begin
        merged = '0;
      end
    endcase
  end

  // ****************************************************************
  // sync request per bank
  // ****************************************************************
  // or of pin, toggle and auto events
  assign req_a = pin_active | (state_r.manual_cnt != 2'h0)
                 | (state_r.auto_cnt_a != 2'h0);
  assign req_b = pin_active | (state_r.manual_cnt != 2'h0)
                 | (state_r.auto_cnt_b != 2'h0);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    state_nxt.ack = (req.read | req.write) & ~state_r.ack;

    // read data stands at the edge that ends the wait
    if (req.read && !state_r.ack) begin
      unique case (req.address)
        `CS_OFS_CTRL:         state_nxt.rdata = 32'(state_r.ctrl);
        `CS_OFS_G4_DELAY:     state_nxt.rdata = 32'(state_r.delay_count);
        `CS_OFS_DIVIDE:       state_nxt.rdata = {8'h00, state_r.grp_divide,
                                                 1'b0, state_r.g4_divide};
        `CS_OFS_BANK_B_WORD:  state_nxt.rdata = state_r.word_b;
        `CS_OFS_BANK_AB_WORD: state_nxt.rdata = state_r.word_ab;
        `CS_OFS_STATUS:       state_nxt.rdata = {15'h0000, state_r.applied_delay,
                                                 grp_held, state_r.hold_b,
                                                 state_r.hold_a, pin_active};
        default:              state_nxt.rdata = 32'h00000000;
      endcase
    end

    // one shot counters run down
    if (state_r.manual_cnt != 2'h0) begin
      state_nxt.manual_cnt = state_r.manual_cnt - 2'h1;
    end
    if (state_r.auto_cnt_a != 2'h0) begin
      state_nxt.auto_cnt_a = state_r.auto_cnt_a - 2'h1;
    end
    if (state_r.auto_cnt_b != 2'h0) begin
      state_nxt.auto_cnt_b = state_r.auto_cnt_b - 2'h1;
    end

    // auto event fires after the write delay
    if (state_r.auto_wait != 2'h0) begin
      state_nxt.auto_wait = state_r.auto_wait - 2'h1;
      if (state_r.auto_wait == 2'h1) begin
        state_nxt.auto_cnt_b = ONESHOT;
        if (state_r.auto_both) begin
          state_nxt.auto_cnt_a = ONESHOT;
        end
      end
    end

    if (commit_wr) begin
      unique case (req.address)
        `CS_OFS_CTRL: begin
          state_nxt.ctrl = ctrl_wr;
          if (ctrl_wr.sync_polarity_invert != state_r.ctrl.sync_polarity_invert) begin
            state_nxt.manual_cnt = ONESHOT;
          end
        end
        `CS_OFS_G4_DELAY: state_nxt.delay_count = delay_wr;
        `CS_OFS_DIVIDE: begin
          state_nxt.g4_divide = (merged[DIV_W-1:0] == '0) ? DIV_W'(1)
                                : merged[DIV_W-1:0];
          state_nxt.grp_divide[0] = merged[`CS_DIV_G1_LSB +: 4];
          state_nxt.grp_divide[1] = merged[`CS_DIV_G2_LSB +: 4];
          state_nxt.grp_divide[2] = merged[`CS_DIV_G3_LSB +: 4];
        end
        `CS_OFS_BANK_B_WORD: begin
          state_nxt.word_b = merged;
          if (state_r.ctrl.auto_sync_enable) begin
            state_nxt.auto_wait = AUTO_CYC;
            state_nxt.auto_both = 1'b0;
          end
        end
        `CS_OFS_BANK_AB_WORD: begin
          state_nxt.word_ab = merged;
          if (state_r.ctrl.auto_sync_enable) begin
            state_nxt.auto_wait = AUTO_CYC;
            state_nxt.auto_both = 1'b1;
          end
        end
        default: begin
          state_nxt.ctrl = state_r.ctrl;
        end
      endcase
    end

    // registered sync request and its history
    state_nxt.hold_a = req_a;
    state_nxt.hold_b = req_b;
    state_nxt.pipe_a = {state_r.pipe_a[6:0], state_r.hold_a};
    state_nxt.pipe_b = {state_r.pipe_b[6:0], state_r.hold_b};

    // current coarse count applied on each bank B event while group 4 sync exclude is clear
    if (req_b && !state_r.hold_b && !state_r.ctrl.group_sync_exclude[3]) begin
      state_nxt.applied_delay = state_r.delay_count;
    end

    state_nxt.half_step_out = state_nxt.ctrl.group4_half_step;
  end

  // ****************************************************************
  // group controls
  // ****************************************************************
  always_comb begin
    grp_assert[0] = state_r.pipe_a[LOW_G13-1];
    grp_assert[1] = state_r.pipe_a[LOW_G13-1];
    grp_assert[2] = state_r.pipe_b[LOW_G13-1];
    grp_assert[3] = (state_r.g4_divide > DIV_W'(1)) ? state_r.pipe_b[LOW_G4_DN-1]
                    : state_r.pipe_b[LOW_G4_D1-1];
    grp_hold = {state_r.hold_b, state_r.hold_b, state_r.hold_a, state_r.hold_a};
    for (int g = 0; g < 3; g++) begin
      // extra offset when bit is clear
      grp_wait[g] = state_r.ctrl.fixed_offset_power_down[g] ? RELEASE
                    : RELEASE + OFFSET;
      grp_div[g]  = DIV_W'(state_r.grp_divide[g]);
    end
    // count 5 lines up with group 3, longer drop pipe taken back
    grp_wait[3] = RELEASE + 11'(state_r.applied_delay)
                  - ((state_r.g4_divide > DIV_W'(1)) ? 11'(LOW_G4_DN - LOW_G13)
                                                     : 11'(LOW_G4_D1 - LOW_G13));
    grp_div[3]  = state_r.g4_divide;
  end

  for (genvar g = 0; g < 4; g++) begin : g_grp
    group_divider #(
      .DIV_W (DIV_W)
    ) u_div (
      .clock_i     (clock_i),
      .rst_i       (rst_i),
      .enable_i    (~state_r.ctrl.group_sync_exclude[g]),
      .assert_i    (grp_assert[g]),
      .bank_hold_i (grp_hold[g]),
      .wait_i      (grp_wait[g]),
      .divide_i    (grp_div[g]),
      .clk_o       (group_clk_o[g]),
      .held_o      (grp_held[g])
    );
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_r               <= '0;
      state_r.ctrl          <= ctrl_t'(`CS_CTRL_RST);
      state_r.delay_count   <= `CS_G4_DELAY_RST;
      state_r.applied_delay <= `CS_G4_DELAY_RST;
      state_r.g4_divide     <= `CS_G4_DIV_RST;
      state_r.grp_divide    <= {3{`CS_GRP_DIV_RST}};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign group4_half_step_o = state_r.half_step_out;

endmodule

`default_nettype wire

// >>> bench/sync_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module sync_host_model (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [7:0] len_i,
  input  wire logic       level_i,
  output logic            sync_pin_o
);
  logic [7:0] left_r;

  // counts the cycles the pin stays active
  // hold above one
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      left_r <= 8'h00;
    end else if (start_i) begin
      left_r <= (len_i < 8'h02) ? 8'h02 : len_i;
    end else if (left_r != 8'h00) begin
      left_r <= left_r - 8'h01;
    end
  end

  // idle level is the inactive one; no recognition cycle is assumed
  // async pin, stable clock
  assign sync_pin_o = (left_r != 8'h00) ? level_i : ~level_i;
endmodule
`default_nettype wire

// >>> bench/clock_output_sync_delay_monitor.sv
`include "clock_sync_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module clock_output_sync_delay_monitor
  import clock_sync_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic [7:0]  address_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0]  byteenable_i,
  input wire logic [31:0] readdata_o,
  input wire logic        waitrequest_o,
  input wire logic        sync_pin_i,
  input wire logic [3:0]  group_clk_o,
  input wire logic        group4_half_step_o
);
  logic [11:0] ctrl_r;
  logic [3:0]  div1_r;
  logic        wr_ok, pin_act, toggle, auto_b, auto_ab;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // ****
  // shadow of written fields
  // ****
  assign wr_ok   = write_i && !waitrequest_o;
  assign pin_act = sync_pin_i ^ ctrl_r[0];
  assign toggle  = wr_ok && address_i == `CS_OFS_CTRL && writedata_i[0] != ctrl_r[0];
  assign auto_b  = wr_ok && ctrl_r[1] && address_i == `CS_OFS_BANK_B_WORD;
  assign auto_ab = wr_ok && ctrl_r[1] && address_i == `CS_OFS_BANK_AB_WORD;

  // keeps control and group 1 divide
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= `CS_CTRL_RST;
      div1_r <= `CS_GRP_DIV_RST;
    end else if (wr_ok && address_i == `CS_OFS_CTRL) begin
      ctrl_r <= writedata_i[11:0];
    end else if (wr_ok && address_i == `CS_OFS_DIVIDE) begin
      div1_r <= writedata_i[15:12];
    end
  end

  // ****
  // properties
  // ****
  sequence s_a_low;
    (group_clk_o[1:0] & ~ctrl_r[3:2]) == 2'h0;
  endsequence
  sequence s_b_low;
    (group_clk_o[2] | ctrl_r[4]) == 1'h0;
  endsequence
  property p_one_wait;
    (read_i || write_i) && waitrequest_o |=> !waitrequest_o;
  endproperty
  property p_unmapped;
    read_i && !waitrequest_o && address_i == 8'h18 |-> readdata_o == 32'h0;
  endproperty
  property p_half_step;
    wr_ok && address_i == `CS_OFS_CTRL |-> ##2 group4_half_step_o == $past(writedata_i[9], 2);
  endproperty
  property p_pin_hold;
    (pin_act && $stable(ctrl_r))[*8] ##1 pin_act[*2] |-> s_a_low and s_b_low;
  endproperty
  property p_toggle;
    toggle |-> ##9 (s_a_low and s_b_low);
  endproperty
  property p_auto_b;
    auto_b |-> ##10 s_b_low;
  endproperty
  property p_auto_b_a;
    auto_b && div1_r == 4'h1 && $changed(group_clk_o[0]) |=> $changed(group_clk_o[0])[*8];
  endproperty
  property p_auto_ab;
    auto_ab |-> ##10 (s_a_low and s_b_low);
  endproperty
  property p_excl_run;
    (ctrl_r[2] && div1_r == 4'h1)[*8] |=> $changed(group_clk_o[0]);
  endproperty

  a_one_wait: assert property (p_one_wait) else $error("access not answered after one wait");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_half_step: assert property (p_half_step) else $error("half step output late");
  a_pin_hold: assert property (p_pin_hold) else $error("pin hold not low");
  a_toggle: assert property (p_toggle) else $error("toggle did not hold");
  a_auto_b: assert property (p_auto_b) else $error("bank b auto hold missing");
  a_auto_b_a: assert property (p_auto_b_a) else $error("bank a disturbed");
  a_auto_ab: assert property (p_auto_ab) else $error("both bank hold missing");
  a_excl_run: assert property (p_excl_run) else $error("excluded group stopped");
endmodule

bind clock_output_sync_delay clock_output_sync_delay_monitor u_mon (
  .clock_i(clock_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .sync_pin_i(sync_pin_i),
  .group_clk_o(group_clk_o), .group4_half_step_o(group4_half_step_o));
`default_nettype wire

// >>> bench/clock_output_sync_delay_tb.sv
`include "clock_sync_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module clock_output_sync_delay_tb
  import clock_sync_pkg::*;
;
  localparam logic [7:0]  RST_A [5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18};
  localparam logic [31:0] RST_V [5] = '{32'h0C0, 32'h5, 32'h00111001, 32'h280, 32'h0};
  localparam logic [31:0] CL_IN [3] = '{32'h2, 32'h3E8, 32'h8};
  localparam logic [31:0] CL_EX [3] = '{32'h5, {22'h0, `CS_G4_DELAY_MAX}, 32'h8};
  logic        clock_i, rst_i, read_i, write_i, sync_pin_i, waitrequest_o;
  logic        group4_half_step_o, host_start, host_level;
  logic [7:0]  address_i, host_len;
  logic [31:0] writedata_i, readdata_o, rd;
  logic [3:0]  byteenable_i, group_clk_o, v1;
  int          n_fail, checks_done;
  int          r[4];

  clock_output_sync_delay DUT (.clock_i(clock_i), .rst_i(rst_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .sync_pin_i(sync_pin_i), .group_clk_o(group_clk_o),
    .group4_half_step_o(group4_half_step_o));
  sync_host_model host (.clock_i(clock_i), .rst_i(rst_i), .start_i(host_start),
    .len_i(host_len), .level_i(host_level), .sync_pin_o(sync_pin_i));

  // ****
  // clock and helpers
  // ****
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock_i);
    address_i <= a;
    writedata_i <= wd;
    write_i <= wr;
    read_i <= !wr;
    // only the watchdog ends a wait that is never answered
    do begin
      @(posedge clock_i);
    end while (waitrequest_o !== 1'b0);
    rd = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask

  task automatic set_ctrl(input logic [31:0] v);
    bus(1'b1, 8'h00, v);
    host_level <= ~v[0];
  endtask

  task automatic pin_on;
    @(posedge clock_i);
    host_len <= 8'h0C;
    host_start <= 1'b1;
    @(posedge clock_i);
    host_start <= 1'b0;
    tick(9);
  endtask

  // records the first rise of each group after the common low
  task automatic measure(input int dly);
    r = '{0, 0, 0, 0};
    for (int i = 1; i < 40; i++) begin
      tick(1);
      if (i == 9) check({28'h0, group_clk_o}, 32'h0);
      for (int k = 0; k < 4; k++) if (i > 9 && group_clk_o[k] && r[k] == 0) r[k] = i;
    end
    check(32'(r[0] > 9), 32'h1);
    check(32'(r[1] - r[0]), 32'h0);
    check(32'(r[2] - r[0]), 32'h5);
    check(32'(r[3] - r[2]), 32'(dly - 5));
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ****
  // test sequence
  // ****
  initial begin
    {rst_i, read_i, write_i, host_start, host_level} = 5'h11;
    address_i = 8'h00;
    writedata_i = 32'h0;
    byteenable_i = 4'hF;
    host_len = 8'h00;
    n_fail = 0;
    checks_done = 0;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, RST_A[i], 32'h0);
      check(rd, RST_V[i]);
    end
    bus(1'b1, 8'h00, 32'h2C0);
    tick(1);
    check({31'h0, group4_half_step_o}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'h04, CL_IN[i]);
      bus(1'b0, 8'h04, 32'h0);
      check(rd, CL_EX[i]);
    end
    bus(1'b0, 8'h14, 32'h0);
    check({22'h0, rd[16:7]}, 32'h5);
    set_ctrl(32'h0C1);
    measure(8);
    bus(1'b0, 8'h14, 32'h0);
    check({22'h0, rd[16:7]}, 32'h8);
    bus(1'b1, 8'h04, 32'h6);
    set_ctrl(32'h0C0);
    measure(6);
    pin_on;
    check({29'h0, group_clk_o[2:0]}, 32'h0);
    bus(1'b0, 8'h14, 32'h0);
    check({31'h0, rd[0]}, 32'h1);
    tick(30);
    set_ctrl(32'h0C1);
    tick(30);
    bus(1'b0, 8'h14, 32'h0);
    check({31'h0, rd[0]}, 32'h0);
    pin_on;
    check({29'h0, group_clk_o[2:0]}, 32'h0);
    tick(30);
    set_ctrl(32'h0C5);
    tick(10);
    pin_on;
    v1 = group_clk_o;
    tick(1);
    check({31'h0, v1[0] ^ group_clk_o[0]}, 32'h1);
    check({31'h0, group_clk_o[1]}, 32'h0);
    tick(30);
    set_ctrl(32'h0C2);
    tick(30);
    bus(1'b1, 8'h0C, 32'h0);
    tick(1);
    v1 = group_clk_o;
    tick(1);
    check({31'h0, v1[2] ^ group_clk_o[2]}, 32'h1);
    tick(7);
    v1 = group_clk_o;
    tick(1);
    check({30'h0, group_clk_o[3:2]}, 32'h0);
    check({31'h0, v1[0] ^ group_clk_o[0]}, 32'h1);
    tick(30);
    bus(1'b1, 8'h10, 32'h0);
    tick(10);
    check({29'h0, group_clk_o[2:0]}, 32'h0);
    tick(30);
    set_ctrl(32'h0C0);
    bus(1'b1, 8'h0C, 32'h0);
    tick(9);
    v1 = group_clk_o;
    tick(1);
    check({31'h0, v1[2] ^ group_clk_o[2]}, 32'h1);
    conclude();
  end

  // cuts a hang short
  initial begin
    repeat (4000) @(posedge clock_i);
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
